// *** design/stsc_pkg.sv ***
`default_nettype none
package stsc_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_UP,
        ST_ON,
        ST_DOWN,
        ST_RETRY
    } stsc_state_t;

    // number of switched rails
    localparam int RAILS = 4;

    // bit positions in the synchronised input vector
    localparam int SB_TRK = 0;
    localparam int SB_EN = 1;
    localparam int SB_MARG = 2;
    localparam int SB_MR = 3;
    localparam int SB_HOLD = 4;
    localparam int SB_FLT = 5;
    localparam int SB_TERR = 6;
    localparam int SB_TDEV = 7;
    localparam int SB_DONE = 8;
    localparam int SB_SRC = 9;
    localparam int SB_OUT = 13;
    localparam int SB_OC = 17;
    localparam int SB_HOT = 21;
    localparam int SYNC_W = 25;
    // idle level of the synchroniser: active-low inputs high
    localparam logic [SYNC_W-1:0] SYNC_RST = 25'h000_003c;

    // timebase: one tick per microsecond
    localparam int CLK_NS = 25;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W = $clog2(TICK_CYC);

    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_RST_DLY = 5'h04;
    localparam logic [4:0] OFS_OC_DLY = 5'h08;
    localparam logic [4:0] OFS_FLT_DLY = 5'h0c;
    localparam logic [4:0] OFS_RETRY_DLY = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;

    // control register fields
    localparam int CB_MASTER = 0;
    localparam int CB_SLAVE = 1;
    localparam int CB_RETRY = 2;
    localparam int CB_SRC = 4;
    localparam int CB_OUTS = 8;
    localparam logic [15:0] CTRL_RST = 16'h0ff0;

    // reset values of the delay registers, in ticks
    localparam logic [15:0] RST_DLY_RST = 16'h00c8;
    localparam logic [15:0] OC_DLY_RST = 16'h0064;
    localparam logic [15:0] FLT_DLY_RST = 16'h03e8;
    localparam logic [15:0] RETRY_DLY_RST = 16'h2710;
endpackage
`default_nettype wire

// *** design/stsc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module stsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    stsc_sync_if.syn sif
);
    // two flop stages
    typedef struct packed {
        logic [W-1:0] ff1; // first stage, read by ff2 only
        logic [W-1:0] ff2; // second stage, safe to use
    } stsc_sync_t;

    stsc_sync_t s_reg;
    stsc_sync_t s_next;

    // shift one stage per clock
    always_comb
    begin
        s_next = s_reg;
        s_next.ff1 = sif.raw;
        s_next.ff2 = s_reg.ff1;
    end

    // registers with constant reset
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= {RST_VAL, RST_VAL};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign sif.q = s_reg.ff2;
endmodule
`default_nettype wire

// *** design/stsc_sync_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// raw pin levels in, synchronised levels out
interface stsc_sync_if #(
    parameter int W = 1
) ();
    logic [W-1:0] raw; // asynchronous levels
    logic [W-1:0] q; // levels on mclk_i
    modport syn (input raw, output q);
    modport use_q (output raw, input q);
endinterface
`default_nettype wire

// *** design/stsc_top.sv ***
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module stsc_top
    import stsc_pkg::*;
#(
    parameter int DLY_W = 16
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // comparator results and logic inputs, asynchronous
    input wire logic track_gate_cmp_i,
    input wire logic enable_i,
    input wire logic margin_n_i,
    input wire logic manual_rst_n_i,
    input wire logic track_err_i,
    input wire logic track_dev_i,
    input wire logic ramp_done_i,
    input wire logic [stsc_pkg::RAILS-1:0] src_ok_i,
    input wire logic [stsc_pkg::RAILS-1:0] out_ok_i,
    input wire logic [stsc_pkg::RAILS-1:0] overcurrent_level_i,
    input wire logic [stsc_pkg::RAILS-1:0] discharged_level_i,
    // analog ramp control
    output logic ramp_up_o,
    output logic ramp_down_o,
    output logic ramp_gen_o,
    output logic shared_ramp_line_oe_n_o,
    // open-drain pins
    input wire logic hold_n_i,
    output logic hold_n_o,
    output logic hold_n_oe_n_o,
    input wire logic track_fail_n_i,
    output logic track_fail_n_o,
    output logic track_fail_n_oe_n_o,
    output logic overcurrent_alarm_n_o,
    output logic overcurrent_alarm_n_oe_n_o,
    output logic card_pullout_ok_o,
    output logic card_pullout_ok_oe_n_o,
    output logic reset_n_o,
    output logic reset_n_oe_n_o
);
    import stsc_pkg::*;

    // whole module state
    typedef struct packed {
        stsc_state_t st; // sequencer state
        logic [TICK_W-1:0] tick_cnt; // timebase divider
        logic tick; // one-cycle timebase pulse
        logic [DLY_W-1:0] flt_cnt; // tracking error age
        logic [DLY_W-1:0] oc_cnt; // overcurrent age
        logic [DLY_W-1:0] rst_cnt; // reset delay count
        logic [DLY_W-1:0] retry_cnt; // retry delay count
        logic fault_flag; // tracking fault latched
        logic oc_flag; // overcurrent latched
        logic rst_rel; // reset released
        logic [15:0] ctrl; // configuration
        logic [DLY_W-1:0] rst_dly;
        logic [DLY_W-1:0] oc_dly;
        logic [DLY_W-1:0] flt_dly;
        logic [DLY_W-1:0] retry_dly;
        logic ack; // bus answer phase
        logic [31:0] rdata; // read data
        logic ramp_up;
        logic ramp_down;
        logic ramp_gen;
        logic line_oe_n;
        logic hold_oe_n;
        logic flt_oe_n;
        logic oc_oe_n;
        logic rem_oe_n;
        logic rst_oe_n;
    } stsc_regs_t;

    localparam stsc_regs_t RST_S = '{
        st: ST_OFF,
        ctrl: CTRL_RST,
        rst_dly: DLY_W'(RST_DLY_RST),
        oc_dly: DLY_W'(OC_DLY_RST),
        flt_dly: DLY_W'(FLT_DLY_RST),
        retry_dly: DLY_W'(RETRY_DLY_RST),
        line_oe_n: 1'b1,
        hold_oe_n: 1'b1,
        flt_oe_n: 1'b1,
        oc_oe_n: 1'b1,
        rem_oe_n: 1'b1,
        rst_oe_n: 1'b0,
        default: '0
    };
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

    stsc_regs_t s_reg;
    stsc_regs_t s_next;

    // byte-lane merge of a delay or control register
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        merge = old;
        if (be[0])
            merge[7:0] = wd[7:0];
        if (be[1])
            merge[15:8] = wd[15:8];
    endfunction

    // input synchroniser
    stsc_sync_if #(.W(SYNC_W)) sif ();
    assign sif.raw = {discharged_level_i, overcurrent_level_i, out_ok_i,
        src_ok_i, ramp_done_i, track_dev_i, track_err_i, track_fail_n_i,
        hold_n_i, manual_rst_n_i, margin_n_i, enable_i, track_gate_cmp_i};
    stsc_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sif(sif)
    );

    // decoded views of synchronised inputs and configuration
    logic trk, en, margin_on, mr_n, hold_in, flt_in;
    logic [RAILS-1:0] src, outs, ocw, hot, src_sel, out_sel;
    logic is_master, is_slave, standalone, autoretry;
    assign trk = sif.q[SB_TRK];
    assign en = sif.q[SB_EN];
    assign margin_on = !sif.q[SB_MARG];
    assign mr_n = sif.q[SB_MR];
    assign hold_in = sif.q[SB_HOLD];
    assign flt_in = sif.q[SB_FLT];
    assign src = sif.q[SB_SRC +: RAILS];
    assign outs = sif.q[SB_OUT +: RAILS];
    assign ocw = sif.q[SB_OC +: RAILS];
    assign hot = sif.q[SB_HOT +: RAILS];
    assign src_sel = s_reg.ctrl[CB_SRC +: RAILS];
    assign out_sel = s_reg.ctrl[CB_OUTS +: RAILS];
    assign is_master = s_reg.ctrl[CB_MASTER];
    assign is_slave = s_reg.ctrl[CB_SLAVE] && !is_master;
    assign standalone = !is_master && !is_slave;
    assign autoretry = s_reg.ctrl[CB_RETRY];

    // next-state logic
    always_comb
    begin
        logic req, go_down, src_low, out_good, trk_bad, rel_cond;
        logic [31:0] rd;
        s_next = s_reg;
        // timebase divider
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt == TICK_LAST)
        begin
            s_next.tick_cnt = '0;
            s_next.tick = 1'b1;
        end
        else
        begin
            s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
        end
        // supply readings masked in margin mode
        src_low = !margin_on && ((src & src_sel) != src_sel);
        out_good = margin_on || ((outs & out_sel) == out_sel);
        go_down = !trk || !en;
        // tracking error age
        if (!sif.q[SB_TERR])
            s_next.flt_cnt = '0;
        else if (s_reg.tick && s_reg.flt_cnt != s_reg.flt_dly)
            s_next.flt_cnt = s_reg.flt_cnt + 1'b1;
        trk_bad = (!margin_on && (sif.q[SB_TDEV] ||
            (sif.q[SB_TERR] && s_reg.flt_cnt == s_reg.flt_dly))) ||
            (!standalone && !flt_in);
        // sequencer
        unique case (s_reg.st)
            ST_OFF:
            begin
                // start needs gate, enable, stable sources, hold free
                if (!go_down && !src_low && hold_in)
                    s_next.st = ST_UP;
            end
            ST_UP:
            begin
                if (go_down)
                    s_next.st = ST_DOWN;
                else if (trk_bad)
                begin
                    s_next.fault_flag = 1'b1;
                    s_next.st = ST_DOWN;
                end
                else if (sif.q[SB_DONE])
                    s_next.st = ST_ON;
            end
            ST_ON:
            begin
                if (go_down)
                    s_next.st = ST_DOWN;
            end
            ST_DOWN:
            begin
                // wait for every rail to discharge
                if (hot == '0)
                    s_next.st = s_reg.fault_flag ? ST_RETRY : ST_OFF;
            end
            ST_RETRY:
            begin
                if (autoretry && s_reg.retry_cnt == s_reg.retry_dly)
                begin
                    s_next.fault_flag = 1'b0;
                    s_next.st = ST_OFF;
                end
                else if (!autoretry && !en)
                begin
                    // latch-off cleared by enable low
                    s_next.fault_flag = 1'b0;
                    s_next.st = ST_OFF;
                end
            end
        endcase
        // retry delay: standalone from fault, shared from line release
        if (!s_reg.fault_flag)
            s_next.retry_cnt = '0;
        else if (s_reg.tick && (standalone || flt_in) &&
            s_reg.retry_cnt != s_reg.retry_dly)
            s_next.retry_cnt = s_reg.retry_cnt + 1'b1;
        // overcurrent, armed only when fully on
        if (s_reg.st != ST_ON)
        begin
            s_next.oc_cnt = '0;
            s_next.oc_flag = 1'b0;
        end
        else if (margin_on || (ocw & out_sel) == '0)
            s_next.oc_cnt = '0;
        else if (s_reg.oc_cnt == s_reg.oc_dly)
            s_next.oc_flag = 1'b1;
        else if (s_reg.tick)
            s_next.oc_cnt = s_reg.oc_cnt + 1'b1;
        // reset delay after rails good and manual reset free
        rel_cond = s_next.st == ST_ON && out_good && mr_n;
        if (!rel_cond)
        begin
            s_next.rst_cnt = '0;
            s_next.rst_rel = 1'b0;
        end
        else if (s_reg.rst_cnt == s_reg.rst_dly)
            s_next.rst_rel = 1'b1;
        else if (s_reg.tick)
            s_next.rst_cnt = s_reg.rst_cnt + 1'b1;
        // registered pin drives
        s_next.ramp_up = s_next.st == ST_UP;
        s_next.ramp_down = s_next.st == ST_DOWN;
        s_next.ramp_gen = !is_slave &&
            (s_next.st == ST_UP || s_next.st == ST_DOWN);
        s_next.line_oe_n = !is_master;
        s_next.hold_oe_n = !(src_low ||
            (is_master && s_next.st == ST_RETRY));
        s_next.flt_oe_n = !(s_next.fault_flag && s_next.st != ST_RETRY);
        s_next.oc_oe_n = !(s_reg.st == ST_ON && s_reg.oc_flag);
        s_next.rem_oe_n = hot == '0;
        s_next.rst_oe_n = s_next.rst_rel;
        // bus slave: one wait state on every access
        req = read_i || write_i;
        s_next.ack = req && !s_reg.ack;
        rd = '0;
        unique case (address_i)
            OFS_CTRL: rd[15:0] = s_reg.ctrl;
            OFS_RST_DLY: rd[DLY_W-1:0] = s_reg.rst_dly;
            OFS_OC_DLY: rd[DLY_W-1:0] = s_reg.oc_dly;
            OFS_FLT_DLY: rd[DLY_W-1:0] = s_reg.flt_dly;
            OFS_RETRY_DLY: rd[DLY_W-1:0] = s_reg.retry_dly;
            OFS_STATUS: rd[10:0] = {flt_in, hold_in, margin_on,
                s_reg.rst_rel, s_reg.oc_flag, s_reg.fault_flag,
                2'b00, s_reg.st};
            default: rd = '0;
        endcase
        if (read_i && !s_reg.ack)
            s_next.rdata = rd;
        // writes land at the answering edge
        if (write_i && s_reg.ack)
        begin
            unique case (address_i)
                OFS_CTRL:
                    s_next.ctrl = merge(s_reg.ctrl, writedata_i,
                        byteenable_i);
                OFS_RST_DLY:
                    s_next.rst_dly = DLY_W'(merge(16'(s_reg.rst_dly),
                        writedata_i, byteenable_i));
                OFS_OC_DLY:
                    s_next.oc_dly = DLY_W'(merge(16'(s_reg.oc_dly),
                        writedata_i, byteenable_i));
                OFS_FLT_DLY:
                    s_next.flt_dly = DLY_W'(merge(16'(s_reg.flt_dly),
                        writedata_i, byteenable_i));
                OFS_RETRY_DLY:
                    s_next.retry_dly = DLY_W'(merge(16'(s_reg.retry_dly),
                        writedata_i, byteenable_i));
                default:
                    s_next.ack = s_next.ack; // unmapped write ignored
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_reg <= RST_S;
        else
            s_reg <= s_next;
    end

    // outputs
    assign waitrequest_o = (read_i || write_i) && !s_reg.ack;
    assign readdata_o = s_reg.rdata;
    assign ramp_up_o = s_reg.ramp_up;
    assign ramp_down_o = s_reg.ramp_down;
    assign ramp_gen_o = s_reg.ramp_gen;
    assign shared_ramp_line_oe_n_o = s_reg.line_oe_n;
    assign hold_n_o = 1'b0;
    assign hold_n_oe_n_o = s_reg.hold_oe_n;
    assign track_fail_n_o = 1'b0;
    assign track_fail_n_oe_n_o = s_reg.flt_oe_n;
    assign overcurrent_alarm_n_o = 1'b0;
    assign overcurrent_alarm_n_oe_n_o = s_reg.oc_oe_n;
    assign card_pullout_ok_o = 1'b0;
    assign card_pullout_ok_oe_n_o = s_reg.rem_oe_n;
    assign reset_n_o = 1'b0;
    assign reset_n_oe_n_o = s_reg.rst_oe_n;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_start_gate: assert property (
        s_reg.st == ST_OFF ##1 s_reg.st == ST_UP |-> $past(trk))
        else $error("ramp started with tracking gate low");
    a_start_enable: assert property (
        s_reg.st == ST_OFF ##1 s_reg.st == ST_UP |-> $past(en))
        else $error("ramp started with enable low");
    a_gate_drop: assert property (
        !trk && s_reg.st == ST_ON |=> s_reg.st == ST_DOWN ##1 ramp_down_o)
        else $error("gate low did not ramp down");
    a_enable_drop: assert property (
        !en && s_reg.st == ST_UP |=> s_reg.st == ST_DOWN)
        else $error("enable low did not ramp down");
    a_slave_quiet: assert property (
        is_slave && $past(is_slave) |-> !ramp_gen_o && shared_ramp_line_oe_n_o)
        else $error("slave generated a ramp");
    a_hold_src: assert property (
        margin_on == 1'b0 && (src & src_sel) != src_sel |=> !hold_n_oe_n_o)
        else $error("hold not driven with low source");
    a_hold_retry: assert property (
        is_master && s_next.st == ST_RETRY |=> !hold_n_oe_n_o)
        else $error("master not holding during retry");
    a_oc_armed: assert property (
        !overcurrent_alarm_n_oe_n_o |-> $past(s_reg.st) == ST_ON)
        else $error("overcurrent outside on state");
    a_rem_level: assert property (
        hot != '0 |=> !card_pullout_ok_oe_n_o)
        else $error("pullout released with rail charged");
    a_rst_ramp: assert property (
        s_reg.st == ST_UP || s_reg.st == ST_DOWN |-> !reset_n_oe_n_o)
        else $error("reset released during ramp");
    a_rst_manual: assert property (
        !mr_n |=> !reset_n_oe_n_o [*2])
        else $error("manual reset not honoured");
    a_rst_delay: assert property (
        $rose(reset_n_oe_n_o) |-> $past(s_reg.rst_cnt) == $past(s_reg.rst_dly))
        else $error("reset released before delay");

    c_power_on: cover property (s_reg.st == ST_UP ##[1:1000] s_reg.st == ST_ON);
    c_fault: cover property ($rose(s_reg.fault_flag));
    c_retry: cover property (s_reg.st == ST_RETRY ##1 s_reg.st == ST_OFF);
    c_overcurrent: cover property ($fell(overcurrent_alarm_n_oe_n_o));
endmodule
`default_nettype wire

// *** tb/stsc_peer_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// peer sequencer sharing the hold and fault lines, both pulled up
module stsc_peer_model (
    input wire logic dut_hold_oe_n_i,
    input wire logic dut_fault_oe_n_i,
    input wire logic peer_hold_i,
    input wire logic peer_fault_i,
    output logic hold_line_o,
    output logic fault_line_o
);
    // wired-and: any party pulling low wins, else the pull-up
    assign hold_line_o = dut_hold_oe_n_i & !peer_hold_i;
    assign fault_line_o = dut_fault_oe_n_i & !peer_fault_i;
endmodule
`default_nettype wire

// *** tb/test_supply_tracking_status_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_supply_tracking_status_control;
    import stsc_pkg::*;
    // bus side
    logic mclk_i, rst_n_i, read_i, write_i, waitrequest_o;
    logic [4:0] address_i;
    logic [3:0] byteenable_i;
    logic [31:0] writedata_i, readdata_o, q;
    // comparator and logic inputs
    logic track_gate_cmp_i, enable_i, margin_n_i, manual_rst_n_i;
    logic track_err_i, track_dev_i, ramp_done_i;
    logic [RAILS-1:0] src_ok_i, out_ok_i, overcurrent_level_i;
    logic [RAILS-1:0] discharged_level_i;
    // outputs and wired lines
    logic ramp_up_o, ramp_down_o, ramp_gen_o, shared_ramp_line_oe_n_o;
    logic hold_n_o, hold_n_oe_n_o, track_fail_n_o, track_fail_n_oe_n_o;
    logic overcurrent_alarm_n_o, overcurrent_alarm_n_oe_n_o;
    logic card_pullout_ok_o, card_pullout_ok_oe_n_o;
    logic reset_n_o, reset_n_oe_n_o;
    logic hold_line, fault_line, peer_hold, peer_fault;
    int miscompares = 0;
    int check_count = 0;

    stsc_top i_dut (.*, .hold_n_i(hold_line), .track_fail_n_i(fault_line));
    stsc_peer_model i_peer (.dut_hold_oe_n_i(hold_n_oe_n_o),
        .dut_fault_oe_n_i(track_fail_n_oe_n_o), .peer_hold_i(peer_hold),
        .peer_fault_i(peer_fault), .hold_line_o(hold_line),
        .fault_line_o(fault_line));

    // 40 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // compare and count
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk_i);
        read_i <= !w;
        write_i <= w;
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        do
            @(negedge mclk_i);
        while (waitrequest_o !== 1'b0);
        @(posedge mclk_i);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, '0, 4'hf);
        chk("readback", e, q);
    endtask

    task automatic st(input logic [2:0] e);
        bus(1'b0, OFS_STATUS, '0, 4'hf);
        chk("state", e, q[2:0]);
    endtask

    // let n settled points pass
    task automatic settle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    // reset values, byte lanes, unmapped place, short delays
    task automatic t_regs;
        rd(OFS_CTRL, CTRL_RST);
        rd(OFS_RST_DLY, RST_DLY_RST);
        rd(OFS_OC_DLY, OC_DLY_RST);
        rd(OFS_FLT_DLY, FLT_DLY_RST);
        rd(OFS_RETRY_DLY, RETRY_DLY_RST);
        bus(1'b1, 5'h18, 32'hffff_ffff, 4'hf);
        rd(5'h18, '0);
        bus(1'b1, OFS_RST_DLY, 32'h0000_ff03, 4'h1);
        rd(OFS_RST_DLY, 32'h0000_0003);
        for (int a = 4; a <= 16; a += 4)
        begin
            bus(1'b1, a[4:0], 32'h0000_0002, 4'hf);
            rd(a[4:0], 32'h0000_0002);
        end
        // reset delay of three ticks keeps the 60-cycle wait check valid
        bus(1'b1, OFS_RST_DLY, 32'h0000_0003, 4'hf);
        rd(OFS_RST_DLY, 32'h0000_0003);
    endtask

    // start refused by gate, enable, own sources and the peer
    task automatic t_blocked;
        @(posedge mclk_i);
        src_ok_i <= 4'hf;
        enable_i <= 1'b1;
        settle(20);
        chk("gate_low", 1'b0, ramp_up_o);
        @(posedge mclk_i);
        track_gate_cmp_i <= 1'b1;
        enable_i <= 1'b0;
        settle(20);
        chk("en_low", 1'b0, ramp_up_o);
        @(posedge mclk_i);
        src_ok_i <= 4'hb;
        enable_i <= 1'b1;
        peer_hold <= 1'b1;
        settle(20);
        chk("src_hold", 1'b0, hold_n_oe_n_o);
        @(posedge mclk_i);
        src_ok_i <= 4'hf;
        settle(20);
        chk("hold_free", 1'b1, hold_n_oe_n_o);
        chk("peer_hold", 1'b0, ramp_up_o);
        @(posedge mclk_i);
        peer_hold <= 1'b0;
        track_gate_cmp_i <= 1'b0;
        enable_i <= 1'b0;
        settle(4);
    endtask

    // full power-up to on with reset release
    task automatic power_up(input logic [15:0] ctrl);
        bus(1'b1, OFS_CTRL, {16'h0000, ctrl}, 4'hf);
        track_gate_cmp_i <= 1'b1;
        enable_i <= 1'b1;
        src_ok_i <= 4'hf;
        discharged_level_i <= 4'hf;
        settle(12);
        chk("ramp_up", 1'b1, ramp_up_o);
        chk("reset_up", 1'b0, reset_n_oe_n_o);
        chk("pullout_up", 1'b0, card_pullout_ok_oe_n_o);
        if (ctrl[1:0] != 2'b00)
        begin
            chk("ramp_gen", ctrl[0], ramp_gen_o);
            chk("ramp_drive", !ctrl[0], shared_ramp_line_oe_n_o);
        end
        @(posedge mclk_i);
        ramp_done_i <= 1'b1;
        out_ok_i <= 4'hf;
        settle(60);
        chk("rst_wait", 1'b0, reset_n_oe_n_o);
        settle(140);
        chk("rst_free", 1'b1, reset_n_oe_n_o);
        st(3'h2);
    endtask

    // ramp down by gate or enable, then discharge three rails, then the last one
    task automatic power_down(input logic use_gate);
        @(posedge mclk_i);
        if (use_gate)
            track_gate_cmp_i <= 1'b0;
        else
            enable_i <= 1'b0;
        settle(8);
        chk("ramp_down", 1'b1, ramp_down_o);
        chk("reset_down", 1'b0, reset_n_oe_n_o);
        @(posedge mclk_i);
        discharged_level_i <= 4'h1;
        settle(8);
        chk("pullout_one", 1'b0, card_pullout_ok_oe_n_o);
        @(posedge mclk_i);
        discharged_level_i <= '0;
        track_gate_cmp_i <= 1'b0;
        enable_i <= 1'b0;
        ramp_done_i <= 1'b0;
        out_ok_i <= '0;
        settle(8);
        chk("pullout_free", 1'b1, card_pullout_ok_oe_n_o);
        st(3'h0);
    endtask

    // overcurrent on one rail while on
    task automatic t_overcurrent;
        @(posedge mclk_i);
        overcurrent_level_i <= 4'h4;
        settle(30);
        chk("oc_wait", 1'b1, overcurrent_alarm_n_oe_n_o);
        settle(120);
        chk("oc_set", 1'b0, overcurrent_alarm_n_oe_n_o);
        @(posedge mclk_i);
        overcurrent_level_i <= '0;
    endtask

    // manual reset and its stretch
    task automatic t_manual;
        @(posedge mclk_i);
        manual_rst_n_i <= 1'b0;
        settle(6);
        chk("mr_low", 1'b0, reset_n_oe_n_o);
        @(posedge mclk_i);
        manual_rst_n_i <= 1'b1;
        settle(60);
        chk("mr_wait", 1'b0, reset_n_oe_n_o);
        settle(140);
        chk("mr_free", 1'b1, reset_n_oe_n_o);
    endtask

    // margin entered after power-up masks a lost output
    task automatic t_margin;
        @(posedge mclk_i);
        margin_n_i <= 1'b0;
        settle(4);
        @(posedge mclk_i);
        out_ok_i <= '0;
        settle(20);
        chk("mg_mask", 1'b1, reset_n_oe_n_o);
        @(posedge mclk_i);
        margin_n_i <= 1'b1;
        settle(10);
        chk("mg_back", 1'b0, reset_n_oe_n_o);
        @(posedge mclk_i);
        out_ok_i <= 4'hf;
        settle(200);
        chk("mg_free", 1'b1, reset_n_oe_n_o);
    endtask

    // fault in ramp-up, then retry timing
    task automatic t_fault(input logic [15:0] ctrl, input logic peer);
        bus(1'b1, OFS_CTRL, {16'h0000, ctrl}, 4'hf);
        track_gate_cmp_i <= 1'b1;
        enable_i <= 1'b1;
        discharged_level_i <= 4'hf;
        settle(12);
        @(posedge mclk_i);
        if (peer)
            peer_fault <= 1'b1;
        else
            track_dev_i <= 1'b1;
        settle(8);
        chk("flt_down", 1'b1, ramp_down_o);
        if (!peer)
            chk("flt_drive", 1'b0, track_fail_n_oe_n_o);
        @(posedge mclk_i);
        track_dev_i <= 1'b0;
        track_gate_cmp_i <= 1'b0;
        discharged_level_i <= '0;
        settle(8);
        st(3'h4);
        if (ctrl[0])
            chk("retry_hold", 1'b0, hold_n_oe_n_o);
        settle(200);
        st(peer ? 3'h4 : 3'h0);
        @(posedge mclk_i);
        peer_fault <= 1'b0;
        settle(200);
        st(3'h0);
        @(posedge mclk_i);
        enable_i <= 1'b0;
    endtask

    // counts, verdict and end of run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial
    begin
        rst_n_i = 1'b0;
        {read_i, write_i, track_gate_cmp_i, enable_i} = '0;
        {track_err_i, track_dev_i, ramp_done_i} = '0;
        {margin_n_i, manual_rst_n_i} = 2'h3;
        {address_i, writedata_i, byteenable_i} = '0;
        {src_ok_i, out_ok_i, overcurrent_level_i} = '0;
        {discharged_level_i, peer_hold, peer_fault} = '0;
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_blocked;
        power_up(16'h0ff0);
        t_overcurrent;
        t_manual;
        t_margin;
        power_down(1'b0);
        power_up(16'h0ff1);
        power_down(1'b1);
        power_up(16'h0ff2);
        power_down(1'b0);
        t_fault(16'h0ff4, 1'b0);
        t_fault(16'h0ff5, 1'b1);
        print_verdict;
    end

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        print_verdict;
    end
endmodule
`default_nettype wire
